// File: rtl/ccra_regs.sv
// What this block does
// - Counter low byte is a read/write register, reset zero, at 0xf9.
// - Counter high byte is a read/write register, reset zero, at 0xfa.
// - High byte reads return a snapshot loaded when the low byte is read.
// - Watchdog enable set: writes to counter low byte leave the counter alone.
// - Watchdog enable set: writes to counter high byte leave the counter alone.
// - Each module has a read/write compare low byte, reset zero, at its address.
// - Each module has a read/write compare high byte, reset zero, at its address.
// - Reload select steers the low-byte address to the auto-reload low byte.
// - Reload select steers the high-byte address to the auto-reload high byte.
// - Writing a compare low byte clears that module's comparator enable.
// - Writing a compare high byte sets that module's comparator enable.
// - Comparator enable is bit 6 of each module mode register.
// - Watchdog enable set: module 2 mode register cannot be modified.
`timescale 1ns/10ps
`default_nettype none

module ccra_regs #(
	parameter int NUM_MODULES = 3
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   nrst,
	// Register bus from the core, same clock
	input  wire ccra_pkg::ccra_sfr_req_t sfr_req,
	output logic [7:0]                  sfr_rdata,
	output logic                        sfr_rvalid,
	// Control levels from the core
	input  wire logic                   watchdog_enable_bit,
	input  wire logic                   reload_access_select,
	input  wire logic                   counter_tick,
	// Register contents for the timing logic
	output logic [15:0]                 free_running_counter,
	output ccra_pkg::ccra_module_t [2:0] module_state
);

	// Address map only covers three modules
	if (NUM_MODULES != ccra_pkg::NUM_MODULES)
	begin : g_bad_count
		$error("ccra_regs: NUM_MODULES must be 3");
	end

	logic [7:0]                   snapshot;
	logic [15:0]                  next_counter;
	logic [7:0]                   next_snapshot;
	logic [7:0]                   next_rdata;
	logic                         next_rvalid;
	ccra_pkg::ccra_module_t [2:0] next_modules;

	// Address match, shared by the write and read decodes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	// Next values of all registers for this access
	always_comb
	begin
		next_counter  = free_running_counter;
		next_snapshot = snapshot;
		next_modules  = module_state;
		next_rdata    = ccra_pkg::RDATA_IDLE;
		next_rvalid   = sfr_req.rd;
		// Count advance; a software write below overrides the byte it writes
		if (counter_tick)
		begin
			next_counter = 16'(free_running_counter + 16'h0001);
		end
		if (sfr_req.wr)
		begin
			// Blocked writes are dropped with no flag raised
			if (hit(sfr_req.addr, ccra_pkg::ADDR_CNT_LO) && !watchdog_enable_bit)
			begin
				next_counter[7:0] = sfr_req.wdata;
			end
			if (hit(sfr_req.addr, ccra_pkg::ADDR_CNT_HI) && !watchdog_enable_bit)
			begin
				next_counter[15:8] = sfr_req.wdata;
			end
			for (int i = 0; i < 3; i++)
			begin
				// Module 2 mode is frozen while it serves as watchdog
				if (!(i == ccra_pkg::WDT_MODULE && watchdog_enable_bit))
				begin
					if (hit(sfr_req.addr, ccra_pkg::ADDR_MODE[i]))
					begin
						next_modules[i].mode = sfr_req.wdata;
					end
				end
				if (hit(sfr_req.addr, ccra_pkg::ADDR_CMP_LO[i]))
				begin
					if (reload_access_select)
					begin
						next_modules[i].reload[7:0] = sfr_req.wdata;
					end
					else
					begin
						next_modules[i].compare[7:0] = sfr_req.wdata;
						if (!(i == ccra_pkg::WDT_MODULE && watchdog_enable_bit))
						begin
							next_modules[i].mode[ccra_pkg::MODE_ECOM_BIT] = 1'b0;
						end
					end
				end
				if (hit(sfr_req.addr, ccra_pkg::ADDR_CMP_HI[i]))
				begin
					if (reload_access_select)
					begin
						next_modules[i].reload[15:8] = sfr_req.wdata;
					end
					else
					begin
						next_modules[i].compare[15:8] = sfr_req.wdata;
						if (!(i == ccra_pkg::WDT_MODULE && watchdog_enable_bit))
						begin
							next_modules[i].mode[ccra_pkg::MODE_ECOM_BIT] = 1'b1;
						end
					end
				end
			end
		end
		// Reads see the values from before this edge
		if (sfr_req.rd)
		begin
			if (hit(sfr_req.addr, ccra_pkg::ADDR_CNT_LO))
			begin
				next_rdata    = free_running_counter[7:0];
				next_snapshot = free_running_counter[15:8];
			end
			if (hit(sfr_req.addr, ccra_pkg::ADDR_CNT_HI))
			begin
				next_rdata = snapshot;
			end
			for (int i = 0; i < 3; i++)
			begin
				if (hit(sfr_req.addr, ccra_pkg::ADDR_MODE[i]))
				begin
					next_rdata = module_state[i].mode;
				end
				if (hit(sfr_req.addr, ccra_pkg::ADDR_CMP_LO[i]))
				begin
					next_rdata = reload_access_select ? module_state[i].reload[7:0]
						: module_state[i].compare[7:0];
				end
				if (hit(sfr_req.addr, ccra_pkg::ADDR_CMP_HI[i]))
				begin
					next_rdata = reload_access_select ? module_state[i].reload[15:8]
						: module_state[i].compare[15:8];
				end
			end
		end
	end

	// Register stage; every output is a flop
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			free_running_counter <= ccra_pkg::CNT_RESET;
			snapshot             <= ccra_pkg::SNAP_RESET;
			sfr_rdata            <= ccra_pkg::RDATA_IDLE;
			sfr_rvalid           <= 1'b0;
			for (int i = 0; i < 3; i++)
			begin
				module_state[i].mode    <= ccra_pkg::MODE_RESET;
				module_state[i].compare <= ccra_pkg::CMP_RESET;
				module_state[i].reload  <= ccra_pkg::RELOAD_RESET;
			end
		end
		else
		begin
			free_running_counter <= next_counter;
			snapshot             <= next_snapshot;
			sfr_rdata            <= next_rdata;
			sfr_rvalid           <= next_rvalid;
			module_state         <= next_modules;
		end
	end

	// Checks, all in the one clock domain
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Shorthand for the access kinds that the checks look at
	logic rd_lo;
	logic rd_hi;
	logic wr_lo;
	logic wr_hi;
	assign rd_lo = sfr_req.rd && sfr_req.addr == ccra_pkg::ADDR_CNT_LO;
	assign rd_hi = sfr_req.rd && sfr_req.addr == ccra_pkg::ADDR_CNT_HI;
	assign wr_lo = sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CNT_LO;
	assign wr_hi = sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CNT_HI;

	property p_snap_load;
		rd_lo |=> snapshot == $past(free_running_counter[15:8]);
	endproperty
	a_snap_load: assert property (p_snap_load) else $error("snapshot not loaded on low read");

	property p_snap_hold;
		!rd_lo |=> $stable(snapshot);
	endproperty
	a_snap_hold: assert property (p_snap_hold) else $error("snapshot moved without low read");

	property p_hi_read;
		rd_lo ##1 rd_hi |=> sfr_rdata == $past(free_running_counter[15:8], 2);
	endproperty
	a_hi_read: assert property (p_hi_read) else $error("high read not from snapshot");

	property p_wdt_lo;
		wr_lo && watchdog_enable_bit && !counter_tick |=> $stable(free_running_counter);
	endproperty
	a_wdt_lo: assert property (p_wdt_lo) else $error("counter low written under watchdog");

	property p_wdt_hi;
		wr_hi && watchdog_enable_bit && !counter_tick |=> $stable(free_running_counter);
	endproperty
	a_wdt_hi: assert property (p_wdt_hi) else $error("counter high written under watchdog");

	property p_cnt_lo_wr;
		wr_lo && !watchdog_enable_bit |=> free_running_counter[7:0] == $past(sfr_req.wdata);
	endproperty
	a_cnt_lo_wr: assert property (p_cnt_lo_wr) else $error("counter low write lost");

	property p_cnt_hi_wr;
		wr_hi && !watchdog_enable_bit |=> free_running_counter[15:8] == $past(sfr_req.wdata);
	endproperty
	a_cnt_hi_wr: assert property (p_cnt_hi_wr) else $error("counter high write lost");

	property p_ecom_clr;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_LO[0] && !reload_access_select
			|=> !module_state[0].mode[ccra_pkg::MODE_ECOM_BIT]
			&& module_state[0].compare[7:0] == $past(sfr_req.wdata);
	endproperty
	a_ecom_clr: assert property (p_ecom_clr) else $error("low compare write wrong");

	property p_ecom_set;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_HI[1] && !reload_access_select
			|=> module_state[1].mode[ccra_pkg::MODE_ECOM_BIT]
			&& module_state[1].compare[15:8] == $past(sfr_req.wdata);
	endproperty
	a_ecom_set: assert property (p_ecom_set) else $error("high compare write wrong");

	property p_reload_lo;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_LO[0] && reload_access_select
			|=> $stable(module_state[0].compare) && $stable(module_state[0].mode)
			&& module_state[0].reload[7:0] == $past(sfr_req.wdata);
	endproperty
	a_reload_lo: assert property (p_reload_lo) else $error("reload low path wrong");

	property p_reload_hi;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_HI[1] && reload_access_select
			|=> $stable(module_state[1].compare)
			&& module_state[1].reload[15:8] == $past(sfr_req.wdata);
	endproperty
	a_reload_hi: assert property (p_reload_hi) else $error("reload high path wrong");

	property p_wdt_mode;
		watchdog_enable_bit |=> module_state[2].mode == $past(module_state[2].mode);
	endproperty
	a_wdt_mode: assert property (p_wdt_mode) else $error("module 2 mode changed under watchdog");

	property p_wdt_read;
		rd_lo && watchdog_enable_bit |=> sfr_rvalid && sfr_rdata == $past(free_running_counter[7:0]);
	endproperty
	a_wdt_read: assert property (p_wdt_read) else $error("counter read wrong under watchdog");

	property p_cnt_lo_read;
		rd_lo |=> sfr_rvalid && sfr_rdata == $past(free_running_counter[7:0]);
	endproperty
	a_cnt_lo_read: assert property (p_cnt_lo_read) else $error("counter low read wrong");

	// Module 2 under watchdog: byte still lands, frozen mode wins over the enable clear
	property p_m2_lo;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_LO[2] && !reload_access_select
			&& watchdog_enable_bit
			|=> $stable(module_state[2].mode)
			&& module_state[2].compare[7:0] == $past(sfr_req.wdata);
	endproperty
	a_m2_lo: assert property (p_m2_lo) else $error("module 2 low write wrong");

	property p_m2_hi;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_HI[2] && !reload_access_select
			&& !watchdog_enable_bit
			|=> module_state[2].mode[ccra_pkg::MODE_ECOM_BIT]
			&& module_state[2].compare[15:8] == $past(sfr_req.wdata);
	endproperty
	a_m2_hi: assert property (p_m2_hi) else $error("module 2 high write wrong");

	property p_m2_ecom_clr;
		sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_LO[2] && !reload_access_select
			&& !watchdog_enable_bit
			|=> !module_state[2].mode[ccra_pkg::MODE_ECOM_BIT];
	endproperty
	a_m2_ecom_clr: assert property (p_m2_ecom_clr) else $error("module 2 enable not cleared");

	// Main scenarios
	c_snapshot_pair: cover property (rd_lo ##1 rd_hi);
	c_blocked_write: cover property (wr_hi && watchdog_enable_bit);
	c_reload_write:  cover property (sfr_req.wr && reload_access_select
		&& sfr_req.addr == ccra_pkg::ADDR_CMP_LO[2]);
	c_ecom_toggle:   cover property (sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_HI[0]
		##[1:8] sfr_req.wr && sfr_req.addr == ccra_pkg::ADDR_CMP_LO[0]);
	c_frozen_mode:   cover property (sfr_req.wr && watchdog_enable_bit
		&& sfr_req.addr == ccra_pkg::ADDR_MODE[2]);

endmodule

`default_nettype wire

// File: rtl/ccra_pkg.sv
package ccra_pkg;

	// Counter byte addresses
	localparam logic [7:0] ADDR_CNT_LO = 8'hf9;
	localparam logic [7:0] ADDR_CNT_HI = 8'hfa;

	// Per-module addresses, index 0 in the lowest byte
	localparam logic [2:0][7:0] ADDR_CMP_LO = {8'heb, 8'he9, 8'hfb};
	localparam logic [2:0][7:0] ADDR_CMP_HI = {8'hec, 8'hea, 8'hfc};
	localparam logic [2:0][7:0] ADDR_MODE   = {8'hdc, 8'hdb, 8'hda};

	// Field positions and fixed module roles
	localparam int MODE_ECOM_BIT = 6;
	localparam int WDT_MODULE    = 2;
	localparam int NUM_MODULES   = 3;

	// Reset values
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [7:0]  SNAP_RESET   = 8'h00;
	localparam logic [7:0]  MODE_RESET   = 8'h00;
	localparam logic [15:0] CMP_RESET    = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [7:0]  RDATA_IDLE   = 8'h00;

	// One register-bus access per cycle
	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ccra_sfr_req_t;

	// Software-visible state of one capture/compare module
	typedef struct packed {
		logic [7:0]  mode;
		logic [15:0] compare;
		logic [15:0] reload;
	} ccra_module_t;

endpackage

// File: dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;

	logic                         clk;
	logic                         nrst;
	ccra_pkg::ccra_sfr_req_t      req;
	logic                         wd;
	logic                         sel;
	logic                         tick;
	logic [7:0]                   rdata;
	logic                         rvalid;
	logic [15:0]                  frc;
	ccra_pkg::ccra_module_t [2:0] mst;
	logic [15:0]                  m_cnt;
	logic [15:0]                  m_cmp [3];
	logic [15:0]                  m_rel [3];
	logic [7:0]                   m_mode [3];
	logic [7:0]                   m_snap;
	logic [7:0]                   e_rd;
	logic [31:0]                  v;
	int                           error_cnt;
	int                           n_compared;
	int                           seed;
	int                           cycles;
	logic [7:0]                   atab [12] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea,
		8'heb, 8'hec, 8'hda, 8'hdb, 8'hdc, 8'h00};

	ccra_regs DUT (
		.clk                  (clk),
		.nrst                 (nrst),
		.sfr_req              (req),
		.sfr_rdata            (rdata),
		.sfr_rvalid           (rvalid),
		.watchdog_enable_bit  (wd),
		.reload_access_select (sel),
		.counter_tick         (tick),
		.free_running_counter (frc),
		.module_state         (mst)
	);

	// Free-running clock, 50 ns period
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task finish_test;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: byte %h, model %h", $time, got, exp);
		end
	endtask

	task chk16(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: counter %h, model %h", $time, got, exp);
		end
	endtask

	task chkm(input ccra_pkg::ccra_module_t got, input ccra_pkg::ccra_module_t exp);
		n_compared++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: module %h, model %h", $time, got, exp);
		end
	endtask

	// Model back to its reset state
	task mreset;
		m_cnt = 16'h0000;
		m_snap = 8'h00;
		for (int n = 0; n < 3; n++)
		begin
			m_cmp[n] = 16'h0000;
			m_rel[n] = 16'h0000;
			m_mode[n] = 8'h00;
		end
	endtask

	// One bus cycle; model steps on pre-edge state, then all results compared
	task cyc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [15:0] nc;
		req = '{addr: a, wr: w, rd: r, wdata: d};
		@(posedge clk);
		e_rd = 8'h00;
		if (a == ccra_pkg::ADDR_CNT_LO)
			e_rd = m_cnt[7:0];
		if (a == ccra_pkg::ADDR_CNT_HI)
			e_rd = m_snap;
		for (int n = 0; n < 3; n++)
		begin
			if (a == ccra_pkg::ADDR_CMP_LO[n])
				e_rd = sel ? m_rel[n][7:0] : m_cmp[n][7:0];
			if (a == ccra_pkg::ADDR_CMP_HI[n])
				e_rd = sel ? m_rel[n][15:8] : m_cmp[n][15:8];
			if (a == ccra_pkg::ADDR_MODE[n])
				e_rd = m_mode[n];
		end
		if (r && a == ccra_pkg::ADDR_CNT_LO)
			m_snap = m_cnt[15:8];
		// Written byte wins over the tick, blocked writes vanish
		nc = m_cnt + {15'h0000, tick};
		if (w && !wd && a == ccra_pkg::ADDR_CNT_LO)
			nc[7:0] = d;
		if (w && !wd && a == ccra_pkg::ADDR_CNT_HI)
			nc[15:8] = d;
		m_cnt = nc;
		for (int n = 0; n < 3; n++)
		begin
			if (w && a == ccra_pkg::ADDR_CMP_LO[n] && sel)
				m_rel[n][7:0] = d;
			if (w && a == ccra_pkg::ADDR_CMP_HI[n] && sel)
				m_rel[n][15:8] = d;
			if (w && a == ccra_pkg::ADDR_CMP_LO[n] && !sel)
			begin
				m_cmp[n][7:0] = d;
				if (!(wd && n == 2))
					m_mode[n][6] = 1'b0;
			end
			if (w && a == ccra_pkg::ADDR_CMP_HI[n] && !sel)
			begin
				m_cmp[n][15:8] = d;
				if (!(wd && n == 2))
					m_mode[n][6] = 1'b1;
			end
			if (w && a == ccra_pkg::ADDR_MODE[n] && !(wd && n == 2))
				m_mode[n] = d;
		end
		#2;
		chk8({7'h00, rvalid}, {7'h00, r});
		chk8(rdata, r ? e_rd : 8'h00);
		chk16(frc, m_cnt);
		for (int n = 0; n < 3; n++)
			chkm(mst[n], {m_mode[n], m_cmp[n], m_rel[n]});
	endtask

	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 10000)
		begin
			error_cnt++;
			finish_test;
		end
	end

	// Main sequence
	initial
	begin
		seed = 86929;
		error_cnt = 0;
		n_compared = 0;
		cycles = 0;
		nrst = 1'b0;
		{wd, sel, tick} = 3'b000;
		req = '0;
		mreset;
		repeat (12) @(posedge clk);
		#2 nrst = 1'b1;
		// Reset values of every address, unmapped one too
		foreach (atab[i]) cyc(1'b1, 1'b0, atab[i], 8'h00);
		// Snapshot across a low-byte carry while counting
		tick = 1'b1;
		cyc(1'b0, 1'b1, 8'hfa, 8'h12);
		cyc(1'b0, 1'b1, 8'hf9, 8'hfe);
		cyc(1'b1, 1'b0, 8'hf9, 8'h00);
		cyc(1'b0, 1'b0, 8'h00, 8'h00);
		cyc(1'b1, 1'b0, 8'hfa, 8'h00);
		// Random traffic; watchdog held a quarter of the time
		for (int k = 0; k < 4000; k++)
		begin
			v = $random(seed);
			wd = v[0] & v[1];
			sel = v[2];
			tick = v[3];
			cyc(v[4], v[5], atab[v[11:8] % 12], v[23:16]);
		end
		// Second reset mid-run, everything back to zero
		nrst = 1'b0;
		req = '0;
		mreset;
		#1;
		// Asynchronous clear, seen before any clock edge
		chk8({7'h00, rvalid}, 8'h00);
		chk8(rdata, 8'h00);
		chk16(frc, m_cnt);
		for (int n = 0; n < 3; n++)
			chkm(mst[n], {m_mode[n], m_cmp[n], m_rel[n]});
		repeat (2) @(posedge clk);
		#2 nrst = 1'b1;
		{wd, sel, tick} = 3'b000;
		foreach (atab[i]) cyc(1'b1, 1'b0, atab[i], 8'h00);
		finish_test;
	end

endmodule

`default_nettype wire
